/* File: logic/sbc_mode_wakeup_control.sv */
// operating mode, reset hold-off and wake-up control
`timescale 1ns/100ps
module sbc_mode_wakeup_control
  import sbc_mode_pkg::*;
#(
  parameter int NCH = 8,
  parameter int RESET_CYC = T_RESET_CYC
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SUPPLY_UV,
  input wire logic IGNITION_WAKE_IN,
  input wire logic LIN_DOMINANT,
  input wire logic LIN_PREWAKE,
  input wire logic SPI_SELECT_N,
  input wire logic SPI_FRAME_VALID,
  input wire logic [15:0] SPI_FRAME_WORD,
  input wire logic DIVIDER_OUTPUT_PIN,
  input wire logic [NCH-1:0] SWITCH_SCAN_STROBE,
  input wire logic [NCH-1:0] SWITCH_INPUT_PIN,
  output logic RESET_OUT_N,
  output logic IRQ_OUT_N,
  output logic REGULATOR_EN,
  output logic WATCHDOG_EN,
  output logic LIN_TRX_EN,
  output logic LIN_TERM_EN,
  output logic LIN_WAKE_RX_EN,
  output logic [NCH-1:0] SWITCH_SOURCE_EN,
  output logic [1:0] MODE,
  output logic [15:0] STATUS_WORD
);

  localparam int RCW = $clog2(RESET_CYC + 1);
  localparam int WCW = $clog2(T_WUDET_CYC + 1);
  localparam int RUNW = WCW + 1;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  mode_t mode_r;
  mode_t mode_nxt;
  src_t src_r;
  logic [15:0] cfg_r;
  logic [15:0] stat_r;
  logic [RCW-1:0] rst_cnt_r;
  logic [WCW-1:0] wu_cnt_r;
  logic [RUNW-1:0] rx_run_r;
  logic rst_busy;
  logic frame_ok;
  logic wd_strap_r;
  logic strap_done_r;
  logic wd_en;
  logic lp_ok;
  logic uv_lvl;
  logic uv_q_r;
  logic ign_lvl;
  logic ign_hi;
  logic ign_lo;
  logic ign_hi_q_r;
  logic ign_arm_r;
  logic ign_wake;
  logic cs_n_lvl;
  logic cs_q_r;
  logic pre_lvl;
  logic dom_lvl;
  logic dom_held;
  logic dom_held_q_r;
  logic dom_seen_r;
  logic rx_en_r;
  logic blk_r;
  logic lin_sleep_wake;
  logic lin_lp_wake;
  logic ev_uv;
  logic ev_any;
  logic irq_n_r;
  logic reset_n_r;
  logic [NCH-1:0] cs_en_r;
  logic [NCH-1:0] cs_int_r;
  logic [NCH-1:0] cs_ie_r;
  logic [NCH-1:0] sw_state_r;
  logic [NCH-1:0] stb_q_r;
  logic [NCH-1:0] src_on;
  logic [NCH-1:0] sw_ev;
  logic [NCH-1:0] src_en_r;
  logic out_reg_en_r;
  logic out_wd_r;
  logic out_lin_r;
  logic out_term_r;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  sync_filter #(.HOLD(1)) u_uv_sync ( // [RULE24]
    .clk(MCLK), .rst_n(RST_N), .din(SUPPLY_UV),
    .level(uv_lvl), .held_hi(), .held_lo()
  );

  sync_filter #(.HOLD(1)) u_cs_sync ( // [RULE24]
    .clk(MCLK), .rst_n(RST_N), .din(SPI_SELECT_N),
    .level(cs_n_lvl), .held_hi(), .held_lo()
  );

  sync_filter #(.HOLD(1)) u_pre_sync ( // [RULE24]
    .clk(MCLK), .rst_n(RST_N), .din(LIN_PREWAKE),
    .level(pre_lvl), .held_hi(), .held_lo()
  );

  sync_filter #(.HOLD(T_DEB_CYC)) u_ign_sync ( // [RULE24]
    .clk(MCLK), .rst_n(RST_N), .din(IGNITION_WAKE_IN),
    .level(ign_lvl), .held_hi(ign_hi), .held_lo(ign_lo)
  );

  sync_filter #(.HOLD(T_BUS_CYC)) u_dom_sync ( // [RULE24]
    .clk(MCLK), .rst_n(RST_N), .din(LIN_DOMINANT),
    .level(dom_lvl), .held_hi(dom_held), .held_lo()
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset hold-off and watchdog strap

  assign rst_busy = (rst_cnt_r != RCW'(RESET_CYC));
  assign frame_ok = SPI_FRAME_VALID && !rst_busy && (mode_r != ST_SLEEP); // [RULE2]

  // the regulator is off in sleep, so the hold-off restarts on every wake from sleep
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      rst_cnt_r <= '0;
      reset_n_r <= 1'b0;
    end
    else
    begin
      if (mode_r == ST_SLEEP)
        rst_cnt_r <= '0;
      else if (rst_busy)
        rst_cnt_r <= rst_cnt_r + RCW'(1);
      reset_n_r <= !rst_busy;
    end
  end

  // strap is read once, the first cycle after reset release
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      strap_done_r <= 1'b0;
      wd_strap_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      wd_strap_r <= !DIVIDER_OUTPUT_PIN; // [RULE1]
    end
  end

  assign wd_en = wd_strap_r && !cfg_r[CFG_WDD]; // [RULE1]

  // whole word replaced per accepted frame
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      cfg_r <= CFG_RESET;
    else if (frame_ok)
      cfg_r <= SPI_FRAME_WORD; // [RULE23]
  end

  ////////////////////////////////////////////////////////////////////////////
  // ignition wake

  // a fresh rising edge after a debounced low is needed before each wake
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      ign_hi_q_r <= 1'b0;
      ign_arm_r <= 1'b0;
    end
    else
    begin
      ign_hi_q_r <= ign_hi;
      // a sleep command taken while high spends the edge already seen
      if (ign_lo)
        ign_arm_r <= 1'b1; // [RULE10]
      else if (ign_wake || (frame_ok && SPI_FRAME_WORD[CFG_SLEEP] && ign_lvl))
        ign_arm_r <= 1'b0; // [RULE10]
    end
  end

  assign ign_wake = ign_hi && !ign_hi_q_r && ign_arm_r && (mode_r != ST_ACTIVE); // [RULE9] [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // LIN wake assessment

  assign lin_sleep_wake = (mode_r == ST_SLEEP) && dom_seen_r && !dom_lvl; // [RULE7]
  assign lin_lp_wake = (mode_r == ST_LOWPWR) && rx_en_r && dom_held && !dom_held_q_r; // [RULE16]

  // receiver powered while bus is low, or after it rises once a dominant phase was seen, and never past the timeout
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      rx_en_r <= 1'b0;
      blk_r <= 1'b0;
      wu_cnt_r <= '0;
      dom_seen_r <= 1'b0;
      dom_held_q_r <= 1'b0;
    end
    else
    begin
      dom_held_q_r <= dom_held;
      if (!pre_lvl)
        blk_r <= 1'b0;
      if (rx_en_r && (wu_cnt_r == WCW'(T_WUDET_CYC)))
      begin
        rx_en_r <= 1'b0; // [RULE17]
        blk_r <= 1'b1;
      end
      else if (lin_sleep_wake || mode_r == ST_ACTIVE || (!pre_lvl && !dom_seen_r))
        rx_en_r <= 1'b0;
      else if (pre_lvl && !blk_r && !cfg_r[CFG_LINE])
        rx_en_r <= 1'b1; // [RULE6]
      if (!rx_en_r)
        wu_cnt_r <= '0;
      else
        wu_cnt_r <= wu_cnt_r + WCW'(1);
      if (!rx_en_r || lin_sleep_wake)
        dom_seen_r <= 1'b0;
      else if (dom_held)
        dom_seen_r <= 1'b1; // [RULE7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch channels

  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      always_ff @(posedge MCLK)
      begin
        if (!RST_N)
        begin
          cs_en_r[i] <= 1'b0;
          cs_int_r[i] <= 1'b0;
          cs_ie_r[i] <= 1'b0;
          sw_state_r[i] <= 1'b0;
          stb_q_r[i] <= 1'b0;
        end
        else
        begin
          if (frame_ok && SPI_FRAME_WORD[CFG_CSPE]
              && SPI_FRAME_WORD[CFG_CSA_LSB +: CSA_W] == CSA_W'(i))
          begin
            cs_en_r[i] <= SPI_FRAME_WORD[CFG_CSE];
            cs_int_r[i] <= SPI_FRAME_WORD[CFG_CSC];
            cs_ie_r[i] <= SPI_FRAME_WORD[CFG_SWITCH_IRQ_ENABLE];
          end
          stb_q_r[i] <= SWITCH_SCAN_STROBE[i];
          if (stb_q_r[i] && !SWITCH_SCAN_STROBE[i])
            sw_state_r[i] <= SWITCH_INPUT_PIN[i]; // [RULE14]
        end
      end

      assign src_on[i] = cs_en_r[i] && (cs_int_r[i] || SWITCH_SCAN_STROBE[i])
                         && !uv_lvl && (mode_r != ST_SLEEP); // [RULE13] [RULE4]
      assign sw_ev[i] = stb_q_r[i] && !SWITCH_SCAN_STROBE[i] && cs_en_r[i] && cs_ie_r[i]
                        && (SWITCH_INPUT_PIN[i] != sw_state_r[i]); // [RULE14] [RULE15]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine

  assign lp_ok = !cfg_r[CFG_LINE] && !wd_en && cs_n_lvl && !frame_ok; // [RULE12]

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      ST_ACTIVE:
        if (frame_ok && SPI_FRAME_WORD[CFG_SLEEP])
          mode_nxt = ST_SLEEP;
        else if (lp_ok)
          mode_nxt = ST_LOWPWR; // [RULE20]
      ST_LOWPWR:
        if (frame_ok && SPI_FRAME_WORD[CFG_SLEEP])
          mode_nxt = ST_SLEEP; // [RULE19]
        else if (!cs_n_lvl)
          mode_nxt = ST_ACTIVE; // [RULE19]
      ST_SLEEP:
        if (lin_sleep_wake || ign_wake)
          mode_nxt = ST_ACTIVE; // [RULE7] [RULE9]
      default:
        mode_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      mode_r <= ST_ACTIVE; // [RULE1]
    else
      mode_r <= mode_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt, wake source and status

  assign ev_uv = uv_lvl && !uv_q_r && (mode_r == ST_ACTIVE); // [RULE3] [RULE5]
  assign ev_any = ev_uv || (|sw_ev) || lin_sleep_wake || lin_lp_wake || ign_wake;

  // a new event in the clearing frame's cycle wins over the clear
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      uv_q_r <= 1'b0;
      irq_n_r <= 1'b1;
      src_r <= SRC_NONE;
    end
    else
    begin
      uv_q_r <= uv_lvl;
      if (ev_any)
        irq_n_r <= 1'b0; // [RULE3] [RULE8] [RULE9] [RULE14] [RULE16] [RULE18]
      else if (frame_ok)
        irq_n_r <= 1'b1;
      if (lin_sleep_wake || lin_lp_wake)
        src_r <= SRC_LIN; // [RULE11] [RULE21]
      else if (ign_wake)
        src_r <= SRC_IGN; // [RULE11] [RULE22]
      else if (ev_any)
        src_r <= SRC_SWUV;
      else if (frame_ok)
        src_r <= SRC_NONE;
    end
  end

  // snapshot at frame start, so a config change shows in the next frame
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      // the select synchroniser leaves reset low; starting low avoids a false edge
      cs_q_r <= 1'b0;
      stat_r <= STAT_RESET;
    end
    else
    begin
      cs_q_r <= cs_n_lvl;
      if (cs_q_r && !cs_n_lvl)
      begin
        stat_r <= 16'(sw_state_r); // [RULE23]
        stat_r[ST_SRC_HI:ST_SRC_LO] <= src_r; // [RULE11]
        stat_r[ST_MODE_LSB +: 2] <= mode_r;
        stat_r[ST_WD] <= wd_en;
        stat_r[ST_LIN] <= cfg_r[CFG_LINE];
        stat_r[ST_UV] <= uv_lvl;
        stat_r[ST_IGN] <= ign_lvl;
      end
    end
  end

  // inhibit under undervoltage leaves the config bits untouched
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      out_reg_en_r <= 1'b1;
      out_wd_r <= 1'b0;
      out_lin_r <= 1'b0;
      out_term_r <= 1'b1;
      src_en_r <= '0;
    end
    else
    begin
      out_reg_en_r <= (mode_r != ST_SLEEP); // [RULE1] [RULE7]
      out_term_r <= (mode_r != ST_SLEEP); // [RULE7]
      out_wd_r <= wd_en && (mode_r != ST_SLEEP) && !rst_busy;
      out_lin_r <= cfg_r[CFG_LINE] && !uv_lvl && (mode_r == ST_ACTIVE); // [RULE4]
      src_en_r <= src_on;
    end
  end

  assign RESET_OUT_N = reset_n_r;
  assign IRQ_OUT_N = irq_n_r;
  assign REGULATOR_EN = out_reg_en_r;
  assign WATCHDOG_EN = out_wd_r;
  assign LIN_TRX_EN = out_lin_r;
  assign LIN_TERM_EN = out_term_r;
  assign LIN_WAKE_RX_EN = rx_en_r;
  assign SWITCH_SOURCE_EN = src_en_r;
  assign MODE = mode_r;
  assign STATUS_WORD = stat_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_sleep_wake;
    (mode_r == ST_SLEEP) && lin_sleep_wake ##1 (mode_r == ST_ACTIVE) && !IRQ_OUT_N;
  endsequence

  a_spi_ignored: assert property ( // [RULE2]
    rst_busy && SPI_FRAME_VALID |=> $stable(cfg_r))
    else $error("frame taken during reset hold-off");

  a_uv_irq: assert property ( // [RULE3]
    ev_uv |=> !IRQ_OUT_N)
    else $error("undervoltage did not raise interrupt");

  a_uv_inhibit: assert property ( // [RULE4]
    uv_lvl ##1 uv_lvl |-> !LIN_TRX_EN && (SWITCH_SOURCE_EN == '0))
    else $error("function not inhibited under undervoltage");

  a_sleep_quiet: assert property ( // [RULE5]
    (mode_r == ST_SLEEP) && !lin_sleep_wake && !ign_wake |=> (mode_r == ST_SLEEP))
    else $error("sleep left without wake");

  a_lin_wake: assert property ( // [RULE7]
    s_sleep_wake |=> REGULATOR_EN && LIN_TERM_EN && (src_r == SRC_LIN))
    else $error("LIN wake did not restore supply and flag");

  a_ign_wake: assert property ( // [RULE9]
    (mode_r == ST_SLEEP) && ign_wake && !lin_sleep_wake
      |=> (mode_r == ST_ACTIVE) && (src_r == SRC_IGN) && !IRQ_OUT_N)
    else $error("ignition wake not handled");

  a_lp_entry: assert property ( // [RULE12]
    (mode_r == ST_LOWPWR) && ($past(mode_r) == ST_ACTIVE) |-> $past(lp_ok))
    else $error("low-power entered while busy");

  a_lp_stays: assert property ( // [RULE16]
    lin_lp_wake && cs_n_lvl |=> (mode_r == ST_LOWPWR) && !IRQ_OUT_N)
    else $error("LIN wake left low-power");

  // consecutive cycles with the wake receiver powered, saturating
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      rx_run_r <= '0;
    else if (!rx_en_r)
      rx_run_r <= '0;
    else if (rx_run_r != RUNW'(T_WUDET_CYC + 2))
      rx_run_r <= rx_run_r + RUNW'(1);
  end

  a_wudet_end: assert property ( // [RULE17]
    rx_run_r <= RUNW'(T_WUDET_CYC + 1))
    else $error("bus assessment exceeded timeout");

  a_cs_exit: assert property ( // [RULE19]
    (mode_r == ST_LOWPWR) && !cs_n_lvl && !(frame_ok && SPI_FRAME_WORD[CFG_SLEEP])
      |=> (mode_r == ST_ACTIVE))
    else $error("select did not leave low-power");

  a_sw_irq: assert property ( // [RULE14]
    (|sw_ev) |=> !IRQ_OUT_N && $changed(sw_state_r))
    else $error("switch change did not interrupt");

endmodule

/* File: logic/sbc_mode_pkg.sv */
// constants, encodings and timing for the mode and wake-up controller
// Operation
// (RULE1) power-up: active, regulator on, watchdog per strap
// (RULE2) ignore SPI while reset output held low
// (RULE3) supply undervoltage in active mode pulls interrupt
// (RULE4) undervoltage inhibits switches and LIN, keeps config
// (RULE5) undervoltage in sleep causes no action
// (RULE6) sleep: bus below pre-wake powers wake receiver
// (RULE7) LIN fall, long dominant, rise wakes device
// (RULE8) LIN wake pulls interrupt, flags LIN source
// (RULE9) debounced ignition high wakes device, interrupts
// (RULE10) after sleep, ignition must stay low first
// (RULE11) wake source recorded in status word
// (RULE12) low-power only with LIN, watchdog off, idle SPI
// (RULE13) strobe rising edge enables switch current source
// (RULE14) strobe fall latches switch; change interrupts if enabled
// (RULE15) disabled current source never interrupts
// (RULE16) low-power: long dominant bus interrupts, mode kept
// (RULE17) low-power bus assessment ends by timeout
// (RULE18) low-power: debounced ignition interrupts, mode kept
// (RULE19) chip select low leaves low-power, then adopts config
// (RULE20) unchanged config returns to low-power after select
// (RULE21) LIN wake: source field reads 11
// (RULE22) ignition wake: source field reads 10
// (RULE23) each frame overwrites config; status shows next frame
// (RULE24) async inputs synchronised before use; switch input pins and the divider strap are used unsynchronised
package sbc_mode_pkg;

  localparam int CLK_NS = 40;
  localparam int T_BUS_NS = 30_000;
  localparam int T_BUS_CYC = (T_BUS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_DEB_NS = 100_000;
  localparam int T_DEB_CYC = (T_DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WUDET_NS = 150_000;
  localparam int T_WUDET_CYC = T_WUDET_NS / CLK_NS;
  localparam int T_RESET_NS = 4_000_000;
  localparam int T_RESET_CYC = (T_RESET_NS + CLK_NS - 1) / CLK_NS;

  // configuration word bit positions
  localparam int CFG_LINE = 12;
  localparam int CFG_SLEEP = 11;
  localparam int CFG_CSPE = 8;
  localparam int CFG_CSA_LSB = 5;
  localparam int CSA_W = 3;
  localparam int CFG_CSE = 4;
  localparam int CFG_CSC = 2;
  localparam int CFG_SWITCH_IRQ_ENABLE = 1;
  localparam int CFG_WDD = 0;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // status word bit positions
  localparam int ST_SRC_HI = 15;
  localparam int ST_SRC_LO = 14;
  localparam int ST_MODE_LSB = 12;
  localparam int ST_WD = 11;
  localparam int ST_LIN = 10;
  localparam int ST_UV = 9;
  localparam int ST_IGN = 8;
  localparam logic [15:0] STAT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_SWUV = 2'b01,
    SRC_IGN = 2'b10,
    SRC_LIN = 2'b11
  } src_t;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_LOWPWR = 2'b01,
    ST_SLEEP = 2'b10
  } mode_t;

endpackage

/* File: logic/sync_filter.sv */
// two-stage synchroniser with stable-level run counter
`timescale 1ns/100ps
module sync_filter
  import sbc_mode_pkg::*;
#(
  parameter int HOLD = 1,
  parameter int CW = $clog2(HOLD + 1)
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic level,
  output logic held_hi,
  output logic held_lo
);

  logic meta_r;
  logic sync_r;
  logic lvl_r;
  logic [CW-1:0] run_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  // run counts cycles the synchronised level has been unchanged
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lvl_r <= 1'b0;
      run_r <= '0;
    end
    else
    begin
      lvl_r <= sync_r;
      if (sync_r != lvl_r)
        run_r <= '0;
      else if (run_r != CW'(HOLD))
        run_r <= run_r + CW'(1);
    end
  end

  assign level = lvl_r;
  assign held_hi = lvl_r && (run_r == CW'(HOLD));
  assign held_lo = !lvl_r && (run_r == CW'(HOLD));

endmodule

/* File: tb/sbc_host_model.sv */
// host side model: chip select, frame strobe and switch scan strobes
`timescale 1ns/100ps
module sbc_host_model
  import sbc_mode_pkg::*;
#(
  parameter int NCH = 8
)
(
  input wire logic clk,
  input wire logic reset_out_n,
  output logic select_n,
  output logic frame_valid,
  output logic [15:0] frame_word,
  output logic [NCH-1:0] strobe
);
  initial
  begin
    select_n = 1'b1;
    frame_valid = 1'b0;
    frame_word = 16'h5a5a;
    strobe = '0;
  end
  task automatic sel(input logic v);
    @(negedge clk);
    select_n = v;
  endtask
  // early is only for probing the refusal during the reset hold-off
  task automatic frame(input logic [15:0] w, input bit early);
    if (!early)
      wait (reset_out_n === 1'b1);
    repeat (3) @(negedge clk);
    frame_word = w;
    frame_valid = 1'b1;
    @(negedge clk);
    frame_valid = 1'b0;
    // released word lines show junk, never the word just sent
    frame_word = ~w;
  endtask
  task automatic stb(input logic [NCH-1:0] m);
    @(negedge clk);
    strobe = m;
  endtask
endmodule

/* File: tb/sbc_mode_wakeup_control_tb.sv */
// self-checking bench for the mode and wake-up controller
`timescale 1ns/100ps
module sbc_mode_wakeup_control_tb
  import sbc_mode_pkg::*;
();
  localparam int RC = 20;
  localparam int NCH = 8;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic uv, ign, dom, pre, strap;
  logic [NCH-1:0] pins;
  logic [NCH-1:0] strobe, src_en;
  logic sel_n, fval, rst_out_n, irq_n, reg_en, wd_en, trx_en, term_en, wrx_en;
  logic [15:0] fword, stat;
  logic [1:0] mode;
  int errors = 0;
  int checked = 0;
  int ncyc = 0;
  int seed;
  logic [15:0] exp_cfg = 16'h0000;
  logic [NCH-1:0] latched = '0;

  always #20 mclk = ~mclk;

  sbc_mode_wakeup_control #(.NCH(NCH), .RESET_CYC(RC)) dut (
    .MCLK(mclk), .RST_N(rst_n), .SUPPLY_UV(uv), .IGNITION_WAKE_IN(ign),
    .LIN_DOMINANT(dom), .LIN_PREWAKE(pre), .SPI_SELECT_N(sel_n),
    .SPI_FRAME_VALID(fval), .SPI_FRAME_WORD(fword), .DIVIDER_OUTPUT_PIN(strap),
    .SWITCH_SCAN_STROBE(strobe), .SWITCH_INPUT_PIN(pins), .RESET_OUT_N(rst_out_n),
    .IRQ_OUT_N(irq_n), .REGULATOR_EN(reg_en), .WATCHDOG_EN(wd_en),
    .LIN_TRX_EN(trx_en), .LIN_TERM_EN(term_en), .LIN_WAKE_RX_EN(wrx_en),
    .SWITCH_SOURCE_EN(src_en), .MODE(mode), .STATUS_WORD(stat));

  sbc_host_model #(.NCH(NCH)) host (
    .clk(mclk), .reset_out_n(rst_out_n), .select_n(sel_n),
    .frame_valid(fval), .frame_word(fword), .strobe(strobe));

  // edges spent with the host held in reset after release
  always @(posedge mclk)
    if (!rst_n)
      ncyc <= 0;
    else if (!rst_out_n)
      ncyc <= ncyc + 1;

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input int exp);
    checked++;
    if (seen !== 16'(exp))
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // model: status shows the previous config, mode follows the new one
  task automatic xfer(input logic [15:0] w);
    logic [1:0] m;
    m = w[CFG_SLEEP] ? ST_SLEEP : (!w[CFG_LINE] && w[CFG_WDD]) ? ST_LOWPWR : ST_ACTIVE;
    host.sel(1'b0);
    host.frame(w, 1'b0);
    host.sel(1'b1);
    cyc(4);
    chk("status lin", stat[ST_LIN], exp_cfg[CFG_LINE]);
    chk("mode", mode, m);
    exp_cfg = w;
  endtask

  ////////////////////////////////////////
  initial
  begin
    #(40ns * 80000);
    errors++;
    summarize();
  end

  initial
  begin
    seed = $urandom(32'h57df);
    {uv, ign, dom, pre, strap} = 5'h00;
    pins = '0;
    cyc(8);
    rst_n = 1'b1;
    chk("reset out", rst_out_n, 0);
    chk("regulator", reg_en, 1);
    chk("mode", mode, ST_ACTIVE);
    cyc(3);
    host.sel(1'b0);
    host.frame(16'h1000, 1'b1);
    host.sel(1'b1);
    wait (rst_out_n === 1'b1);
    cyc(2);
    chk("holdoff", 16'(ncyc), 16'(RC + 1));
    chk("lin trx", trx_en, 0);
    chk("watchdog", wd_en, 1);
    $display("test power-up done");

    xfer(16'h1000);
    chk("lin trx", trx_en, 1);
    uv = 1'b1;
    cyc(6);
    chk("irq", irq_n, 0);
    chk("lin trx", trx_en, 0);
    uv = 1'b0;
    cyc(6);
    chk("lin trx", trx_en, 1);
    xfer(16'h1000);
    chk("irq", irq_n, 1);
    $display("test undervoltage done");

    // ch3 under strobe control and interrupt enabled, ch5 source off
    xfer(16'h1172);
    xfer(16'h11a2);
    for (int k = 0; k < 2; k++)
    begin
      pins = NCH'($urandom);
      pins[3] = (k == 0) ? ~latched[3] : latched[3];
      host.stb('1);
      cyc(3);
      chk("source en", src_en[3], 1);
      chk("source en", src_en[5], 0);
      host.stb('0);
      cyc(3);
      chk("irq", irq_n, (pins[3] != latched[3]) ? 0 : 1);
      latched[3] = pins[3];
      xfer(16'h1000);
      chk("latched", stat[3], latched[3]);
    end
    $display("test switch done");

    xfer(16'h0001);
    host.sel(1'b0);
    cyc(5);
    chk("mode", mode, ST_ACTIVE);
    host.frame(16'h0001, 1'b0);
    host.sel(1'b1);
    cyc(5);
    chk("mode", mode, ST_LOWPWR);
    cyc(T_DEB_CYC);
    ign = 1'b1;
    cyc(T_DEB_CYC + 10);
    chk("irq", irq_n, 0);
    chk("mode", mode, ST_LOWPWR);
    ign = 1'b0;
    xfer(16'h0001);
    pre = 1'b1;
    dom = 1'b1;
    cyc(T_BUS_CYC + 10);
    dom = 1'b0;
    cyc(5);
    chk("irq", irq_n, 0);
    chk("mode", mode, ST_LOWPWR);
    cyc(T_WUDET_CYC - T_BUS_CYC);
    chk("wake rx", wrx_en, 0);
    pre = 1'b0;
    xfer(16'h0001);
    $display("test low-power done");

    xfer(16'h0800);
    chk("regulator", reg_en, 0);
    uv = 1'b1;
    cyc(10);
    chk("mode", mode, ST_SLEEP);
    chk("irq", irq_n, 1);
    uv = 1'b0;
    pre = 1'b1;
    cyc(5);
    chk("wake rx", wrx_en, 1);
    dom = 1'b1;
    cyc(T_BUS_CYC + 10);
    dom = 1'b0;
    pre = 1'b0;
    cyc(5);
    chk("mode", mode, ST_ACTIVE);
    chk("regulator", reg_en, 1);
    chk("termination", term_en, 1);
    chk("irq", irq_n, 0);
    xfer(16'h1000);
    chk("source", stat[15:14], SRC_LIN);
    $display("test lin wake done");

    ign = 1'b1;
    cyc(20);
    xfer(16'h0800);
    cyc(T_DEB_CYC + 10);
    chk("mode", mode, ST_SLEEP);
    ign = 1'b0;
    cyc(T_DEB_CYC + 10);
    ign = 1'b1;
    cyc(T_DEB_CYC / 2);
    ign = 1'b0;
    cyc(10);
    chk("mode", mode, ST_SLEEP);
    cyc(T_DEB_CYC + 10);
    ign = 1'b1;
    cyc(T_DEB_CYC + 10);
    chk("mode", mode, ST_ACTIVE);
    chk("irq", irq_n, 0);
    xfer(16'h1000);
    chk("source", stat[15:14], SRC_IGN);
    $display("test ignition wake done");

    // second power-up with the strap high: the watchdog must stay off
    strap = 1'b1;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
    chk("reset out", rst_out_n, 0);
    chk("mode", mode, ST_ACTIVE);
    wait (rst_out_n === 1'b1);
    cyc(2);
    chk("holdoff", 16'(ncyc), 16'(RC + 1));
    chk("watchdog", wd_en, 0);
    chk("regulator", reg_en, 1);
    $display("test strap done");
    summarize();
  end
endmodule
